// *** design/feedback_monitor_pkg.sv ***
// Purpose: Constants, register map and codes for the feedback monitor bank
// Assumes: 250 MHz core clock, 100 ms timeout tick
// Notes:   Word-addressed register port, 32-bit data
//
// What this block does
// - Gate needed and gate low: release off
// - Gate skipped by default: runs without gate
// - Auto restart: release once circuits closed
// - Ack wired in auto mode: warning
// - Manual restart: release on ack rising edge
// - Controlled restart: release on ack falling edge
// - Manual/controlled without ack: violation 15
// - After fault, only ack re-enables release
// - Power-up test: area interrupted once first
// - Power-up test still needs ack when manual
// - Fourteen independent monitor channels
// - Feedback not opened in time: fault, release off
// - Feedback not closed in time: fault, hold
// - Fault contact closed in fault state
// - Timer value output shows running timer
// - Diagnostic word shows block state code
// - Timeout defaults to 3.0 seconds
// - Restart mode defaults to manual
// - Timeout 0.1 to 3.0 s, 0.1 s steps
// - Codes f011 open fail, f012 close fail

package feedback_monitor_pkg;

  // ************************************************************
  // Sizes and timing
  // ************************************************************
  localparam int unsigned CHANNELS    = 14;
  localparam int unsigned ADDR_W      = 6;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned DIAG_W      = 16;
  localparam int unsigned TMR_W       = 5;
  localparam int unsigned PRESCALE_W  = 25;
  localparam int unsigned CLK_KHZ     = 250000;
  localparam int unsigned TICK_MS     = 100;
  localparam int unsigned TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam logic [TMR_W-1:0] FT_MIN     = 5'h01;
  localparam logic [TMR_W-1:0] FT_MAX     = 5'h1e;
  localparam logic [TMR_W-1:0] FT_DEFAULT = 5'h1e;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [ADDR_W-1:0] CFG_BASE  = 6'h00;
  localparam logic [ADDR_W-1:0] STAT_BASE = 6'h10;
  localparam int unsigned CFG_GATE_BIT  = 0;
  localparam int unsigned CFG_MODE_LSB  = 1;
  localparam int unsigned CFG_TEST_BIT  = 3;
  localparam int unsigned CFG_WIRED_BIT = 4;
  localparam int unsigned CFG_FT_LSB    = 8;
  localparam int unsigned ST_DIAG_LSB   = 0;
  localparam int unsigned ST_TMR_LSB    = 16;
  localparam int unsigned ST_REL_BIT    = 21;
  localparam int unsigned ST_FAULT_BIT  = 22;
  localparam int unsigned ST_WARN_BIT   = 23;
  localparam int unsigned ST_VIOL_LSB   = 24;
  localparam logic [7:0]  RULE_NO_RESET = 8'h0f;

  // ************************************************************
  // Modes and reset values
  // ************************************************************
  localparam logic [1:0] MODE_AUTO       = 2'h0;
  localparam logic [1:0] MODE_MANUAL     = 2'h1;
  localparam logic [1:0] MODE_CONTROLLED = 2'h2;
  localparam logic       GATE_RESET      = 1'h0;
  localparam logic       TEST_RESET      = 1'h0;
  localparam logic       WIRED_RESET     = 1'h1;

  // ************************************************************
  // Diagnostic codes
  // ************************************************************
  localparam logic [DIAG_W-1:0] DIAG_OFF        = 16'h0000;
  localparam logic [DIAG_W-1:0] DIAG_ARMED      = 16'h2001;
  localparam logic [DIAG_W-1:0] DIAG_WAIT_RISE  = 16'h2003;
  localparam logic [DIAG_W-1:0] DIAG_WAIT_FALL  = 16'h2004;
  localparam logic [DIAG_W-1:0] DIAG_WAIT_CLOSE = 16'h2007;
  localparam logic [DIAG_W-1:0] DIAG_RELEASED   = 16'h8001;
  localparam logic [DIAG_W-1:0] DIAG_WAIT_OPEN  = 16'h801a;
  localparam logic [DIAG_W-1:0] DIAG_FAIL_OPEN  = 16'hf011;
  localparam logic [DIAG_W-1:0] DIAG_FAIL_CLOSE = 16'hf012;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_ARMED,
    ST_WAIT_RISE,
    ST_WAIT_FALL,
    ST_RELEASE,
    ST_DROP,
    ST_FAULT
  } mon_state_e;

endpackage : feedback_monitor_pkg

// *** design/feedback_monitor.sv ***
// Purpose: Bank of feedback monitors for external contactors and valves
// Assumes: Inputs synchronous to core_clk; clk_en low freezes all state
// Notes:   Register reads answer one cycle after the read strobe

`timescale 1ns/10ps
`default_nettype none

module feedback_monitor #(
  parameter int unsigned TICK_CYCLES = feedback_monitor_pkg::TICK_CYCLES
) (
  input  wire logic                                 core_clk,
  input  wire logic                                 rst_b,
  input  wire logic                                 clk_en,
  input  wire logic [feedback_monitor_pkg::CHANNELS-1:0] activate_coil,
  input  wire logic [feedback_monitor_pkg::CHANNELS-1:0] feedback_coil,
  input  wire logic [feedback_monitor_pkg::CHANNELS-1:0] ack_coil,
  input  wire logic [feedback_monitor_pkg::CHANNELS-1:0] ext_gate,
  input  wire logic [feedback_monitor_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [feedback_monitor_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [feedback_monitor_pkg::DATA_W-1:0]   reg_rdata,
  output logic      [feedback_monitor_pkg::CHANNELS-1:0] safe_release_contact,
  output logic      [feedback_monitor_pkg::CHANNELS-1:0] fault_contact,
  output logic      [feedback_monitor_pkg::CHANNELS-1:0] cfg_warning,
  output logic      [feedback_monitor_pkg::CHANNELS-1:0] cfg_violation,
  output logic [feedback_monitor_pkg::CHANNELS-1:0][feedback_monitor_pkg::TMR_W-1:0]
                                                    timer_value_out,
  output logic [feedback_monitor_pkg::CHANNELS-1:0][feedback_monitor_pkg::DIAG_W-1:0]
                                                    diag_word_out
);

  localparam int unsigned N  = feedback_monitor_pkg::CHANNELS;
  localparam int unsigned TW = feedback_monitor_pkg::TMR_W;
  localparam int unsigned DW = feedback_monitor_pkg::DIAG_W;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [feedback_monitor_pkg::PRESCALE_W-1:0] prescale;
    logic                                        tick;
    feedback_monitor_pkg::mon_state_e [N-1:0]    state;
    logic [N-1:0][TW-1:0]                        count;
    logic [N-1:0]                                ack_prev;
    logic [N-1:0]                                pup_seen;
    logic [N-1:0]                                fail_close;
    logic [N-1:0]                                release_c;
    logic [N-1:0]                                fault_c;
    logic [N-1:0]                                warn;
    logic [N-1:0]                                viol;
    logic [N-1:0][DW-1:0]                        diag;
    logic [N-1:0]                                cfg_gate;
    logic [N-1:0]                                cfg_test;
    logic [N-1:0]                                cfg_wired;
    logic [N-1:0][1:0]                           cfg_mode;
    logic [N-1:0][TW-1:0]                        cfg_ft;
    logic [feedback_monitor_pkg::DATA_W-1:0]     rdata;
  } mon_s;

  mon_s st_q;
  mon_s st_d;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    logic          en_ok;
    logic          area_ok;
    logic          ack_rise;
    logic          ack_fall;
    logic          ack_ok;
    logic          pup_ok;
    logic          timed_out;
    logic [TW-1:0] ft_w;
    logic [31:0]   word;
    en_ok     = 1'b0;
    area_ok   = 1'b0;
    ack_rise  = 1'b0;
    ack_fall  = 1'b0;
    ack_ok    = 1'b0;
    pup_ok    = 1'b0;
    timed_out = 1'b0;
    ft_w      = '0;
    word      = '0;
    st_d      = st_q;

    // Shared 100 ms tick for all channel timers
    st_d.tick = 1'b0;
    if (st_q.prescale == feedback_monitor_pkg::PRESCALE_W'(TICK_CYCLES - 1))
    begin
      st_d.prescale = '0;
      st_d.tick     = 1'b1;
    end
    else
    begin
      st_d.prescale = st_q.prescale + 1'b1;
    end

    // Register writes
    ft_w = reg_wdata[feedback_monitor_pkg::CFG_FT_LSB +: TW];
    if (ft_w < feedback_monitor_pkg::FT_MIN)
    begin
      ft_w = feedback_monitor_pkg::FT_MIN;
    end
    else if (ft_w > feedback_monitor_pkg::FT_MAX)
    begin
      ft_w = feedback_monitor_pkg::FT_MAX;
    end
    for (int i = 0; i < N; i++)
    begin
      if (reg_wr && reg_addr == feedback_monitor_pkg::ADDR_W'(feedback_monitor_pkg::CFG_BASE + i))
      begin
        st_d.cfg_gate[i]  = reg_wdata[feedback_monitor_pkg::CFG_GATE_BIT];
        st_d.cfg_mode[i]  = reg_wdata[feedback_monitor_pkg::CFG_MODE_LSB +: 2];
        st_d.cfg_test[i]  = reg_wdata[feedback_monitor_pkg::CFG_TEST_BIT];
        st_d.cfg_wired[i] = reg_wdata[feedback_monitor_pkg::CFG_WIRED_BIT];
        st_d.cfg_ft[i]    = ft_w;
      end
    end

    // Independent channels
    for (int i = 0; i < N; i++)
    begin
      en_ok     = !st_q.cfg_gate[i] || ext_gate[i];
      area_ok   = activate_coil[i] && feedback_coil[i];
      ack_rise  = ack_coil[i] && !st_q.ack_prev[i];
      ack_fall  = !ack_coil[i] && st_q.ack_prev[i];
      ack_ok    = (st_q.cfg_mode[i] == feedback_monitor_pkg::MODE_CONTROLLED) ? ack_fall
                                                                             : ack_rise;
      pup_ok    = !st_q.cfg_test[i] || st_q.pup_seen[i];
      timed_out = st_q.count[i] >= st_q.cfg_ft[i];
      st_d.ack_prev[i] = ack_coil[i];
      st_d.pup_seen[i] = st_q.pup_seen[i] || !activate_coil[i];
      st_d.warn[i] = st_q.cfg_wired[i]
                     && st_q.cfg_mode[i] == feedback_monitor_pkg::MODE_AUTO;
      st_d.viol[i] = !st_q.cfg_wired[i]
                     && st_q.cfg_mode[i] != feedback_monitor_pkg::MODE_AUTO;

      unique case (st_q.state[i])
        feedback_monitor_pkg::ST_OFF:
        begin
          if (en_ok)
          begin
            st_d.state[i] = feedback_monitor_pkg::ST_ARMED;
          end
        end
        feedback_monitor_pkg::ST_ARMED:
        begin
          if (!en_ok)
          begin
            st_d.state[i] = feedback_monitor_pkg::ST_OFF;
          end
          else if (area_ok && pup_ok && !st_d.viol[i])
          begin
            st_d.count[i] = '0;
            if (st_q.cfg_mode[i] == feedback_monitor_pkg::MODE_AUTO)
            begin
              st_d.state[i] = feedback_monitor_pkg::ST_RELEASE;
            end
            else if (st_q.cfg_mode[i] == feedback_monitor_pkg::MODE_CONTROLLED)
            begin
              st_d.state[i] = feedback_monitor_pkg::ST_WAIT_FALL;
            end
            else
            begin
              st_d.state[i] = feedback_monitor_pkg::ST_WAIT_RISE;
            end
          end
        end
        feedback_monitor_pkg::ST_WAIT_RISE,
        feedback_monitor_pkg::ST_WAIT_FALL:
        begin
          if (!en_ok)
          begin
            st_d.state[i] = feedback_monitor_pkg::ST_OFF;
          end
          else if (!area_ok)
          begin
            st_d.state[i] = feedback_monitor_pkg::ST_ARMED;
          end
          else if ((st_q.state[i] == feedback_monitor_pkg::ST_WAIT_RISE && ack_rise)
                   || (st_q.state[i] == feedback_monitor_pkg::ST_WAIT_FALL && ack_fall))
          begin
            st_d.state[i] = feedback_monitor_pkg::ST_RELEASE;
            st_d.count[i] = '0;
          end
        end
        feedback_monitor_pkg::ST_RELEASE:
        begin
          if (!en_ok || !activate_coil[i])
          begin
            st_d.state[i] = feedback_monitor_pkg::ST_DROP;
            st_d.count[i] = '0;
          end
          else if (feedback_coil[i] && timed_out)
          begin
            st_d.state[i]      = feedback_monitor_pkg::ST_FAULT;
            st_d.fail_close[i] = 1'b0;
          end
          else if (feedback_coil[i] && st_q.tick)
          begin
            st_d.count[i] = st_q.count[i] + 1'b1;
          end
        end
        feedback_monitor_pkg::ST_DROP:
        begin
          if (feedback_coil[i])
          begin
            st_d.state[i] = feedback_monitor_pkg::ST_ARMED;
          end
          else if (timed_out)
          begin
            st_d.state[i]      = feedback_monitor_pkg::ST_FAULT;
            st_d.fail_close[i] = 1'b1;
          end
          else if (st_q.tick)
          begin
            st_d.count[i] = st_q.count[i] + 1'b1;
          end
        end
        feedback_monitor_pkg::ST_FAULT:
        begin
          if (ack_ok && area_ok && en_ok)
          begin
            st_d.count[i] = '0;
            if (st_q.cfg_mode[i] == feedback_monitor_pkg::MODE_AUTO)
            begin
              st_d.state[i] = feedback_monitor_pkg::ST_ARMED;
            end
            else
            begin
              st_d.state[i] = feedback_monitor_pkg::ST_RELEASE;
            end
          end
        end
        default:
        begin
          st_d.state[i] = feedback_monitor_pkg::ST_OFF;
        end
      endcase

      st_d.release_c[i] = st_d.state[i] == feedback_monitor_pkg::ST_RELEASE;
      st_d.fault_c[i]   = st_d.state[i] == feedback_monitor_pkg::ST_FAULT;

      unique case (st_d.state[i])
        feedback_monitor_pkg::ST_ARMED:     st_d.diag[i] = feedback_monitor_pkg::DIAG_ARMED;
        feedback_monitor_pkg::ST_WAIT_RISE: st_d.diag[i] = feedback_monitor_pkg::DIAG_WAIT_RISE;
        feedback_monitor_pkg::ST_WAIT_FALL: st_d.diag[i] = feedback_monitor_pkg::DIAG_WAIT_FALL;
        feedback_monitor_pkg::ST_DROP:      st_d.diag[i] = feedback_monitor_pkg::DIAG_WAIT_CLOSE;
        feedback_monitor_pkg::ST_RELEASE:
          st_d.diag[i] = feedback_coil[i] ? feedback_monitor_pkg::DIAG_WAIT_OPEN
                                          : feedback_monitor_pkg::DIAG_RELEASED;
        feedback_monitor_pkg::ST_FAULT:
          st_d.diag[i] = st_d.fail_close[i] ? feedback_monitor_pkg::DIAG_FAIL_CLOSE
                                            : feedback_monitor_pkg::DIAG_FAIL_OPEN;
        default:                            st_d.diag[i] = feedback_monitor_pkg::DIAG_OFF;
      endcase
    end

    // Register reads
    st_d.rdata = '0;
    for (int i = 0; i < N; i++)
    begin
      if (reg_rd && reg_addr == feedback_monitor_pkg::ADDR_W'(feedback_monitor_pkg::CFG_BASE + i))
      begin
        word = '0;
        word[feedback_monitor_pkg::CFG_GATE_BIT]    = st_q.cfg_gate[i];
        word[feedback_monitor_pkg::CFG_MODE_LSB +: 2] = st_q.cfg_mode[i];
        word[feedback_monitor_pkg::CFG_TEST_BIT]    = st_q.cfg_test[i];
        word[feedback_monitor_pkg::CFG_WIRED_BIT]   = st_q.cfg_wired[i];
        word[feedback_monitor_pkg::CFG_FT_LSB +: TW] = st_q.cfg_ft[i];
        st_d.rdata = word;
      end
      if (reg_rd && reg_addr == feedback_monitor_pkg::ADDR_W'(feedback_monitor_pkg::STAT_BASE + i))
      begin
        word = '0;
        word[feedback_monitor_pkg::ST_DIAG_LSB +: DW] = st_q.diag[i];
        word[feedback_monitor_pkg::ST_TMR_LSB +: TW]  = st_q.count[i];
        word[feedback_monitor_pkg::ST_REL_BIT]        = st_q.release_c[i];
        word[feedback_monitor_pkg::ST_FAULT_BIT]      = st_q.fault_c[i];
        word[feedback_monitor_pkg::ST_WARN_BIT]       = st_q.warn[i];
        word[feedback_monitor_pkg::ST_VIOL_LSB +: 8]  = st_q.viol[i]
          ? feedback_monitor_pkg::RULE_NO_RESET : 8'h00;
        st_d.rdata = word;
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q           <= '0;
      st_q.cfg_gate  <= {N{feedback_monitor_pkg::GATE_RESET}};
      st_q.cfg_test  <= {N{feedback_monitor_pkg::TEST_RESET}};
      st_q.cfg_wired <= {N{feedback_monitor_pkg::WIRED_RESET}};
      st_q.cfg_mode  <= {N{feedback_monitor_pkg::MODE_MANUAL}};
      st_q.cfg_ft    <= {N{feedback_monitor_pkg::FT_DEFAULT}};
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

  assign reg_rdata            = st_q.rdata;
  assign safe_release_contact = st_q.release_c;
  assign fault_contact        = st_q.fault_c;
  assign cfg_warning          = st_q.warn;
  assign cfg_violation        = st_q.viol;
  assign timer_value_out      = st_q.count;
  assign diag_word_out        = st_q.diag;

  // ************************************************************
  // Checks on every channel, covers on channel 0
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  for (genvar c = 0; c < N; c++)
  begin : g_chk
    AST_GATE_OFF: assert property (
      clk_en && st_q.cfg_gate[c] && !ext_gate[c] |=> !safe_release_contact[c])
      else $error("Release with gate low");
    AST_AUTO_REL: assert property (
      clk_en && st_q.state[c] == feedback_monitor_pkg::ST_ARMED
      && st_q.cfg_mode[c] == feedback_monitor_pkg::MODE_AUTO && activate_coil[c]
      && feedback_coil[c] && !st_q.cfg_test[c] && !st_q.cfg_gate[c]
      |=> safe_release_contact[c]) else $error("Auto release missing");
    AST_WARN: assert property (
      clk_en && st_q.cfg_wired[c] && st_q.cfg_mode[c] == feedback_monitor_pkg::MODE_AUTO
      |=> cfg_warning[c]) else $error("Warning missing");
    AST_RISE_REL: assert property (
      clk_en && st_q.state[c] == feedback_monitor_pkg::ST_WAIT_RISE
      && activate_coil[c] && feedback_coil[c] && ack_coil[c] && !st_q.ack_prev[c]
      && !st_q.cfg_gate[c] |=> safe_release_contact[c] && timer_value_out[c] == '0)
      else $error("Rising ack release missing");
    AST_FALL_REL: assert property (
      clk_en && st_q.state[c] == feedback_monitor_pkg::ST_WAIT_FALL
      && activate_coil[c] && feedback_coil[c] && !ack_coil[c] && st_q.ack_prev[c]
      && !st_q.cfg_gate[c] |=> safe_release_contact[c])
      else $error("Falling ack release missing");
    AST_VIOL: assert property (
      clk_en && !st_q.cfg_wired[c] && st_q.cfg_mode[c] != feedback_monitor_pkg::MODE_AUTO
      |=> cfg_violation[c] ##0 !$rose(safe_release_contact[c]))
      else $error("Violation missing");
    AST_PUP: assert property (
      st_q.cfg_test[c] && !st_q.pup_seen[c] |-> !safe_release_contact[c])
      else $error("Release before interrupt");
    AST_OPEN_FAIL: assert property (
      clk_en && st_q.state[c] == feedback_monitor_pkg::ST_RELEASE
      && activate_coil[c] && feedback_coil[c] && (!st_q.cfg_gate[c] || ext_gate[c])
      && st_q.count[c] >= st_q.cfg_ft[c] |=> fault_contact[c] && !safe_release_contact[c]
      && diag_word_out[c] == feedback_monitor_pkg::DIAG_FAIL_OPEN)
      else $error("Open timeout missed");
    AST_CLOSE_FAIL: assert property (
      clk_en && st_q.state[c] == feedback_monitor_pkg::ST_DROP
      && !feedback_coil[c] && st_q.count[c] >= st_q.cfg_ft[c]
      |=> fault_contact[c] && diag_word_out[c] == feedback_monitor_pkg::DIAG_FAIL_CLOSE)
      else $error("Close timeout missed");
    AST_FAULT_OUT: assert property (
      fault_contact[c] == (diag_word_out[c] == feedback_monitor_pkg::DIAG_FAIL_OPEN
      || diag_word_out[c] == feedback_monitor_pkg::DIAG_FAIL_CLOSE)
      && !(fault_contact[c] && safe_release_contact[c]))
      else $error("Fault contact wrong");
    AST_ACK_CLR: assert property (
      clk_en && fault_contact[c] && activate_coil[c] && feedback_coil[c] && !st_q.cfg_gate[c]
      && st_q.cfg_mode[c] == feedback_monitor_pkg::MODE_MANUAL
      && ack_coil[c] && !st_q.ack_prev[c] |=> !fault_contact[c] && safe_release_contact[c])
      else $error("Ack did not clear fault");
  end

  COV_RELEASE: cover property (!safe_release_contact[0] ##1 safe_release_contact[0]);
  COV_OPEN_FAIL: cover property (diag_word_out[0] == feedback_monitor_pkg::DIAG_FAIL_OPEN);
  COV_CLOSE_FAIL: cover property (diag_word_out[0] == feedback_monitor_pkg::DIAG_FAIL_CLOSE);
  COV_ACK_CLEAR: cover property (fault_contact[0] ##1 !fault_contact[0]);

endmodule : feedback_monitor

`default_nettype wire

// *** tb/contactor_model.sv ***
// Purpose: Contactor feedback loop model for the monitor bank
// Assumes: Loop closes while release is open, two cycles late
// Notes:   stuck freezes the feedback level of a channel

`timescale 1ns/10ps
`default_nettype none

module contactor_model (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [13:0] sw,
  input  wire logic [13:0] stuck,
  output logic      [13:0] fb
);
  logic [13:0] dly_q;

  // ************************************************************
  // One loop input per channel, inverse of the contact
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dly_q <= 14'h3fff;
      fb    <= 14'h3fff;
    end
    else
    begin
      dly_q <= ~sw;
      fb    <= (stuck & fb) | (~stuck & dly_q);
    end
  end
endmodule : contactor_model

`default_nettype wire

// *** tb/feedback_monitor_tb.sv ***
// Purpose: Directed test of the feedback monitor bank
// Assumes: Timeout tick shortened to 4 cycles
// Notes:   Contactor model closes the feedback loops

`timescale 1ns/10ps
`default_nettype none

module feedback_monitor_tb;
  logic              core_clk = 1'b0;
  logic              rst_b    = 1'b0;
  logic              reg_wr   = 1'b0;
  logic              reg_rd   = 1'b0;
  logic [13:0]       act      = 14'h0020;
  logic [13:0]       ack      = 14'h0000;
  logic [13:0]       gate     = 14'h0000;
  logic [13:0]       stuck    = 14'h0000;
  logic [5:0]        addr     = 6'h00;
  logic [31:0]       wd       = 32'h0;
  logic [13:0]       rel, flt, warn, viol, fb;
  logic [31:0]       rdat, rv;
  logic [13:0][4:0]  tmr;
  logic [13:0][15:0] diag;
  int                n_fail   = 0;
  int                n_checks = 0;

  always #2 core_clk = ~core_clk;

  feedback_monitor #(.TICK_CYCLES(4)) dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1),
    .activate_coil(act), .feedback_coil(fb), .ack_coil(ack), .ext_gate(gate), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdat),
    .safe_release_contact(rel), .fault_contact(flt), .cfg_warning(warn),
    .cfg_violation(viol), .timer_value_out(tmr), .diag_word_out(diag));

  contactor_model partner (.core_clk(core_clk), .rst_b(rst_b), .sw(rel), .stuck(stuck), .fb(fb));

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    addr   <= a;
    wd     <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    addr   <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = rdat;
  endtask : rd

  task automatic pulse(input int i);
    @(posedge core_clk) ack[i] <= 1'b1;
    cyc(2);
    @(posedge core_clk) ack[i] <= 1'b0;
    cyc(4);
  endtask : pulse

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(6'h00);
    chk("cfg0", 32'h0000_1e12, rv);
    rd(6'h3f);
    chk("unmapped", 32'h0, rv);
    wr(6'h01, 32'h0000_0212);
    wr(6'h02, 32'h0000_0000);
    wr(6'h03, 32'h0000_0004);
    wr(6'h04, 32'h0000_0001);
    wr(6'h05, 32'h0000_0008);
    cyc(6);
    chk("rel5 test", 32'h0, 32'(rel[5]));
    @(posedge core_clk) act <= 14'h0000;
    cyc(3);
    @(posedge core_clk) act <= 14'h003f;
    cyc(6);
    chk("rel auto", 32'h24, 32'(rel & 14'h003c));
    chk("viol", 32'h8, 32'(viol));
    rd(6'h13);
    chk("viol code", 32'h0f, 32'(rv[31:24]));
    wr(6'h02, 32'h0000_0010);
    cyc(3);
    chk("warn", 32'h4, 32'(warn));
    @(posedge core_clk) gate[4] <= 1'b1;
    cyc(4);
    chk("rel gate", 32'h1, 32'(rel[4]));
    @(posedge core_clk) stuck[1] <= 1'b1;
    pulse(0);
    pulse(1);
    chk("rel0", 32'h1, 32'(rel[0]));
    chk("diag0", 32'h8001, 32'(diag[0]));
    cyc(20);
    chk("flt1", 32'h1, 32'({rel[1], flt[1]}));
    chk("diag1", 32'hf011, 32'(diag[1]));
    @(posedge core_clk) stuck[1] <= 1'b0;
    pulse(1);
    chk("ack1", 32'h2, 32'({rel[1], flt[1]}));
    wr(6'h03, 32'h0000_0214);
    cyc(2);
    @(posedge core_clk) ack[3] <= 1'b1;
    cyc(4);
    chk("rel3 rise", 32'h0, 32'(rel[3]));
    @(posedge core_clk) ack[3] <= 1'b0;
    cyc(4);
    chk("rel3 fall", 32'h1, 32'(rel[3]));
    @(posedge core_clk) stuck[0] <= 1'b1;
    @(posedge core_clk) act[0] <= 1'b0;
    cyc(140);
    chk("diag0 close", 32'hf012, 32'(diag[0]));
    chk("flt0", 32'h1, 32'(flt[0]));
    chk("tmr0", 32'h1e, 32'(tmr[0]));
    rd(6'h02);
    chk("cfg2 ft min", 32'h0000_0110, rv);
    wr(6'h06, 32'h0000_1f12);
    rd(6'h06);
    chk("cfg6 ft max", 32'h0000_1e12, rv);
    results();
  end

  initial
  begin
    repeat (2000) @(posedge core_clk);
    n_fail++;
    results();
  end
endmodule : feedback_monitor_tb

`default_nettype wire
